// ===== logic/boot_irq_pkg.sv
// Types shared by the boot-mode latch and its pin synchroniser
`include "boot_irq_regs.svh"

package boot_irq_pkg;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_st_t;

  typedef struct packed {
    logic in_reset;
    logic chip_reset;
    logic phase_reset;
    logic [`BIRQ_LINES-1:0] omw;
    logic [`BIRQ_LINES-1:0] prev;
    logic [`BIRQ_LINES-1:0] pend;
    logic [`BIRQ_LINES-1:0] irq;
    logic stop_exit;
  } birq_st_t;

endpackage

// ===== logic/boot_irq_regs.svh
// Constants for the boot-mode latch and external request block
`ifndef BOOT_IRQ_REGS_SVH
`define BOOT_IRQ_REGS_SVH

`define BIRQ_LINES 4
`define BIRQ_LINE_A 0
`define BIRQ_OMW_RESET 4'h0
`define BIRQ_PIN_IDLE 4'hf
`define BIRQ_NONE 4'h0

`endif

// ===== logic/boot_mode_irq.sv
// Boot operating-mode latch and four external interrupt request inputs
`timescale 1ns/1ps
`include "boot_irq_regs.svh"

module boot_mode_irq
  import boot_irq_pkg::*;
(
  input wire logic i_clk, // Core clock, 50 MHz
  input wire logic i_reset_n, // Hardware reset, active low
  input wire logic i_mode_sel_a_ext_request_a_n, // Mode A / request A pin
  input wire logic i_mode_sel_b_ext_request_b_n, // Mode B / request B pin
  input wire logic i_mode_sel_c_ext_request_c_n, // Mode C / request C pin
  input wire logic i_mode_sel_d_ext_request_d_n, // Mode D / request D pin
  input wire logic [`BIRQ_LINES-1:0] i_irq_enable, // Per-line mask, 1 = enabled
  input wire logic [`BIRQ_LINES-1:0] i_irq_edge, // 1 = falling edge, 0 = level
  input wire logic [`BIRQ_LINES-1:0] i_irq_ack, // Clears latched edge request
  input wire logic i_core_stopped, // Core in stop standby
  output logic [`BIRQ_LINES-1:0] o_operating_mode_word, // Latched boot mode
  output logic [`BIRQ_LINES-1:0] o_irq_req, // Requests to core, active high
  output logic o_stop_exit, // Wake from stop, held high while stopped and line A is low
  output logic o_chip_reset, // Chip held in reset
  output logic o_phase_reset // Phase generator reset
);

  birq_st_t st_r;
  birq_st_t st_nxt;
  logic [`BIRQ_LINES-1:0] pins_raw;
  logic [`BIRQ_LINES-1:0] pins;
  logic [`BIRQ_LINES-1:0] fall;
  logic [`BIRQ_LINES-1:0] active;

  assign pins_raw = {i_mode_sel_d_ext_request_d_n, i_mode_sel_c_ext_request_c_n,
                     i_mode_sel_b_ext_request_b_n, i_mode_sel_a_ext_request_a_n};

  genvar g;
  generate
    for (g = 0; g < `BIRQ_LINES; g++)
    begin : g_sync
      pin_sync3 u_sync (
        .i_clk(i_clk),
        .i_pin(pins_raw[g]),
        .o_level(pins[g])
      );
    end
  endgenerate

  // Pins are active low
  assign active = ~pins;
  assign fall = st_r.prev & ~pins;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.in_reset = 1'b0;
    st_nxt.chip_reset = 1'b0;
    st_nxt.phase_reset = 1'b0;
    st_nxt.prev = pins;
    st_nxt.stop_exit = 1'b0;
    if (st_r.in_reset)
    begin
      // First cycle after release: sample mode, seed edge history
      st_nxt.omw = pins;
      st_nxt.pend = `BIRQ_NONE;
      st_nxt.irq = `BIRQ_NONE;
    end
    else
    begin
      // Set wins over acknowledge in the same cycle
      st_nxt.pend = (st_r.pend & ~i_irq_ack) | (fall & i_irq_edge);
      st_nxt.irq = i_irq_enable & ((active & ~i_irq_edge) | (st_nxt.pend & i_irq_edge));
      st_nxt.stop_exit = i_core_stopped & active[`BIRQ_LINE_A];
    end
    if (!i_reset_n)
    begin
      st_nxt.in_reset = 1'b1;
      st_nxt.chip_reset = 1'b1;
      st_nxt.phase_reset = 1'b1;
      st_nxt.omw = st_r.omw;
      st_nxt.prev = `BIRQ_PIN_IDLE;
      st_nxt.pend = `BIRQ_NONE;
      st_nxt.irq = `BIRQ_NONE;
      st_nxt.stop_exit = 1'b0;
    end
  end

  // Mode word keeps its value across reset until the release re-samples it
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      st_r.in_reset <= 1'b1;
      st_r.chip_reset <= 1'b1;
      st_r.phase_reset <= 1'b1;
      st_r.prev <= `BIRQ_PIN_IDLE;
      st_r.pend <= `BIRQ_NONE;
      st_r.irq <= `BIRQ_NONE;
      st_r.stop_exit <= 1'b0;
      st_r.omw <= st_nxt.omw;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_operating_mode_word = st_r.omw;
  assign o_irq_req = st_r.irq;
  assign o_stop_exit = st_r.stop_exit;
  assign o_chip_reset = st_r.chip_reset;
  assign o_phase_reset = st_r.phase_reset;

  // Checks
  a_mode_capture: assert property (@(posedge i_clk) st_r.in_reset && i_reset_n |=> o_operating_mode_word == $past(pins))
    else $error("mode word not captured at release");
  a_mode_hold: assert property (@(posedge i_clk) !st_r.in_reset |=> $stable(o_operating_mode_word))
    else $error("mode word changed outside release");
  a_reset_quiet: assert property (@(posedge i_clk) !i_reset_n |=> o_irq_req == `BIRQ_NONE && !o_stop_exit)
    else $error("request during reset");
  a_reset_hold: assert property (@(posedge i_clk) !i_reset_n |=> o_chip_reset && o_phase_reset)
    else $error("reset outputs not asserted");
  a_reset_end: assert property (@(posedge i_clk) !i_reset_n ##1 i_reset_n |=> !o_chip_reset && !o_phase_reset)
    else $error("reset outputs stuck");
  a_level_req: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !st_r.in_reset && i_irq_enable[0] && !i_irq_edge[0] && !pins[0] |=> o_irq_req[0])
    else $error("level request missed");
  a_mask_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_irq_enable[1] |=> !o_irq_req[1])
    else $error("masked request passed");
  a_edge_req: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !st_r.in_reset && i_irq_edge[2] && i_irq_enable[2] && $fell(pins[2]) ##1
    (i_irq_edge[2] && i_irq_enable[2]) |-> o_irq_req[2])
    else $error("edge request missed");
  a_stop_wake: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !st_r.in_reset && i_core_stopped && !pins[`BIRQ_LINE_A] |=> o_stop_exit)
    else $error("stop exit missed");
  // Pending edge must keep requesting until acknowledged
  a_edge_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !st_r.in_reset && st_r.pend[3] && i_irq_edge[3] && i_irq_enable[3] && !i_irq_ack[3] |=> o_irq_req[3])
    else $error("pending edge request lost");
  // A fall that meets an acknowledge must not be dropped
  a_ack_set_wins: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !st_r.in_reset && fall[3] && i_irq_edge[3] && i_irq_enable[3] && i_irq_ack[3] |=> o_irq_req[3])
    else $error("edge lost to acknowledge");
  c_release: cover property (@(posedge i_clk) !i_reset_n ##1 i_reset_n ##1 o_operating_mode_word != `BIRQ_OMW_RESET);
  c_level_irq: cover property (@(posedge i_clk) !i_irq_edge[2] && o_irq_req[2]);
  c_ack_seen: cover property (@(posedge i_clk) i_irq_ack[3] && st_r.pend[3]);
  c_edge_irq: cover property (@(posedge i_clk) i_irq_edge[0] && o_irq_req[0]);
  c_wake: cover property (@(posedge i_clk) o_stop_exit);

endmodule

// ===== logic/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module pin_sync3
  import boot_irq_pkg::*;
(
  input wire logic i_clk, // Core clock
  input wire logic i_pin, // Asynchronous pin level
  output logic o_level // Filtered, synchronised level
);

  sync_st_t st_r;
  sync_st_t st_nxt;

  // No reset here: the mode code must flow through while reset is held
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3)
    begin
      st_nxt.level = st_r.s3;
    end
  end

  always_ff @(posedge i_clk)
  begin
    st_r <= st_nxt;
  end

  assign o_level = st_r.level;

endmodule

// ===== tb/board_model.sv
// Board logic driving reset and the mode/request pins
`timescale 1ns/1ps
module board_model
(
  input wire logic i_clk, // Core clock
  output logic o_reset_n, // Reset to device
  output logic [3:0] o_pins_n // Pins, pulled up when idle
);
  initial
  begin
    o_reset_n = 1'b0;
    o_pins_n = 4'hf;
  end
  task drive(input logic r, input logic [3:0] p);
    @(posedge i_clk);
    o_reset_n <= r;
    o_pins_n <= p;
  endtask
endmodule

// ===== tb/tb_boot_mode_irq.sv
// Self-checking bench for the boot-mode and request block
`timescale 1ns/1ps
module tb_boot_mode_irq;
  logic i_clk = 1'b0;
  logic rst_n;
  logic [3:0] pins_n, omw, irq;
  logic [3:0] en = 4'hf, edg = 4'h0, ack = 4'h0;
  logic stopped = 1'b0, stop_exit, chip_rst, ph_rst;
  int errors = 0, samples_checked = 0;
  always #10 i_clk = ~i_clk;
  board_model board_model_inst(.i_clk(i_clk), .o_reset_n(rst_n), .o_pins_n(pins_n));
  boot_mode_irq boot_mode_irq_inst(.i_clk(i_clk), .i_reset_n(rst_n),
    .i_mode_sel_a_ext_request_a_n(pins_n[0]), .i_mode_sel_b_ext_request_b_n(pins_n[1]),
    .i_mode_sel_c_ext_request_c_n(pins_n[2]), .i_mode_sel_d_ext_request_d_n(pins_n[3]),
    .i_irq_enable(en), .i_irq_edge(edg), .i_irq_ack(ack), .i_core_stopped(stopped),
    .o_operating_mode_word(omw), .o_irq_req(irq), .o_stop_exit(stop_exit),
    .o_chip_reset(chip_rst), .o_phase_reset(ph_rst));
  task check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task test_boot(input logic [3:0] code);
    board_model_inst.drive(1'b0, code);
    wait_cyc(6);
    check("chip_reset", {3'h0, chip_rst}, 4'h1);
    check("phase_reset", {3'h0, ph_rst}, 4'h1);
    check("irq_in_reset", irq, 4'h0);
    board_model_inst.drive(1'b1, code);
    wait_cyc(1);
    check("mode_word", omw, code);
    check("chip_released", {3'h0, chip_rst}, 4'h0);
    check("phase_released", {3'h0, ph_rst}, 4'h0);
    board_model_inst.drive(1'b1, 4'hf);
    wait_cyc(8);
    check("mode_kept", omw, code);
    $display("test_boot %h done", code);
  endtask
  task test_level;
    board_model_inst.drive(1'b1, 4'h9);
    en <= 4'hd;
    wait_cyc(8);
    check("level_req", irq, 4'h4);
    board_model_inst.drive(1'b1, 4'hf);
    wait_cyc(8);
    check("level_gone", irq, 4'h0);
    $display("test_level done");
  endtask
  task test_edge;
    board_model_inst.drive(1'b1, 4'h7);
    en <= 4'hf;
    edg <= 4'h8;
    wait_cyc(8);
    board_model_inst.drive(1'b1, 4'hf);
    wait_cyc(8);
    check("edge_held", irq, 4'h8);
    @(posedge i_clk) ack <= 4'h8;
    wait_cyc(2);
    @(posedge i_clk) ack <= 4'h0;
    wait_cyc(2);
    check("edge_acked", irq, 4'h0);
    $display("test_edge done");
  endtask
  task test_stop;
    board_model_inst.drive(1'b1, 4'he);
    stopped <= 1'b1;
    en <= 4'h0;
    wait_cyc(8);
    check("stop_exit", {3'h0, stop_exit}, 4'h1);
    board_model_inst.drive(1'b1, 4'hf);
    wait_cyc(8);
    check("stop_quiet", {3'h0, stop_exit}, 4'h0);
    $display("test_stop done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge i_clk);
    for (int m = 0; m < 16; m++)
      test_boot(m[3:0]);
    test_level();
    test_edge();
    test_stop();
    complete_run();
  end
  initial
  begin
    #100000;
    errors++;
    complete_run();
  end
endmodule
